// [rtl/lsa_pkg.sv]
// Package for the lifecycle state and access control block.
// Assumes a 32-bit APB slave with word-aligned registers.
package lsa_pkg;

  typedef enum logic [2:0]
  {
    LC_SECURE_DEV    = 3'b000,
    LC_NONSECURE_DEV = 3'b001,
    LC_DEPLOYED      = 3'b010,
    LC_DEBUG_LOCKED  = 3'b011,
    LC_BOOT_LOCKED   = 3'b100
  } lsa_lc_t;

  typedef enum logic [0:0]
  {
    SEQ_IDLE  = 1'b0,
    SEQ_ERASE = 1'b1
  } lsa_seq_t;

  // Register byte offsets.
  localparam logic [7:0] REG_CMD_OFS    = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_DEBUG_OFS  = 8'h08;

  // Command codes written to the command register.
  localparam logic [3:0] CMD_ADVANCE     = 4'h1;
  localparam logic [3:0] CMD_ERASE_ALL   = 4'h2;
  localparam logic [3:0] CMD_DIS_ERASE   = 4'h3;
  localparam logic [3:0] CMD_INJ_SECURE  = 4'h4;
  localparam logic [3:0] CMD_INJ_NONSEC  = 4'h5;
  localparam logic [3:0] CMD_REGRESS_NS  = 4'h6;
  localparam logic [3:0] CMD_REGRESS_SEC = 4'h7;

  // Status register field positions.
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_KEY_NS     = 3;
  localparam int ST_KEY_SEC    = 4;
  localparam int ST_ERASE_DIS  = 5;
  localparam int ST_PROTECT    = 6;
  localparam int ST_BUSY       = 7;
  localparam int ST_REJECT     = 8;
  localparam int ST_DBG_LSB    = 9;
  localparam int ST_ERASE_AVL  = 11;

  // Debug levels.
  localparam logic [1:0] DEBUG_REFUSED        = 2'h0;
  localparam logic [1:0] DEBUG_NONSECURE_ONLY = 2'h1;
  localparam logic [1:0] DEBUG_FULL_ACCESS    = 2'h2;

  // Serial read classes.
  localparam logic [1:0] SER_CLASS_ID     = 2'h0;
  localparam logic [1:0] SER_CLASS_NONSEC = 2'h1;
  localparam logic [1:0] SER_CLASS_SECURE = 2'h2;

  // Values after reset.
  localparam lsa_lc_t    LC_RESET_STATE = LC_SECURE_DEV;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

endpackage

// [rtl/lsa_flag.sv]
// One sticky flag: set by hardware, optionally cleared; set wins.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps
module lsa_flag
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  logic flag_reg;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      flag_reg <= 1'b0;
    else if (ce_in)
    begin
      // A set that meets a clear in the same cycle must not be lost.
      if (set_in)
        flag_reg <= 1'b1;
      else if (clr_in)
        flag_reg <= 1'b0;
    end
  end

  assign flag_out = flag_reg;

endmodule // lsa_flag

// [rtl/lsa_lifecycle.sv]
// Lifecycle state controller with full-erase and serial read gating.
// Assumes an APB master on CLK_SYS_IN and flash/auth logic on the same clock.
//
// Contract
// - Permanent block protection forbids full erase forever.
// - Accepted full erase wipes flash, enters secure development.
// - Full erase clears secure and non-secure regions.
// - Deployed with both keys regresses to either development.
// - Deployed with non-secure key only reaches non-secure.
// - Non-secure to secure development needs secure key.
// - No erase, no non-secure key: no way back.
// - Non-secure development hides secure code from readers.
// - Restricted states return only identity information.
// - Boot-locked state: no serial access, no erase.
// - Disabled full erase is never re-enabled.
// - Secure key injectable only in secure development.
// - States map to full, non-secure or refused debug.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module lsa_lifecycle
  import lsa_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        CE_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        PROTECT_IN,
  input  wire logic        AUTH_OK_IN,
  output logic             ERASE_REQ_OUT,
  output logic             ERASE_SEC_OUT,
  output logic             ERASE_NS_OUT,
  input  wire logic        ERASE_DONE_IN,
  input  wire logic        SER_REQ_IN,
  input  wire logic [1:0]  SER_CLASS_IN,
  output logic             SER_GRANT_OUT,
  output logic             SER_DENY_OUT,
  output logic [1:0]       DBG_LEVEL_OUT,
  output logic [2:0]       LC_STATE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  lsa_lc_t     state_reg;
  lsa_seq_t    seq_reg;
  logic        secure_regress_key;
  logic        nonsecure_regress_key;
  logic        erase_dis;
  logic        reject_flag;
  logic        access;
  logic        wr_cmd;
  logic        wr_status;
  logic        mapped;
  logic [3:0]  cmd;
  logic        busy;
  logic        erase_avail;
  logic        ok_adv;
  logic        ok_erase;
  logic        ok_inj_s;
  logic        ok_inj_ns;
  logic        ok_reg_ns;
  logic        ok_reg_s;
  logic        accept;
  logic        do_reject;
  logic [1:0]  dbg_level;
  logic [31:0] status_word;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  assign access    = CE_IN & PSEL_IN & PENABLE_IN;
  assign mapped    = (PADDR_IN == REG_CMD_OFS) | (PADDR_IN == REG_STATUS_OFS) | (PADDR_IN == REG_DEBUG_OFS);
  assign wr_cmd    = access & PWRITE_IN & (PADDR_IN == REG_CMD_OFS);
  assign wr_status = access & PWRITE_IN & (PADDR_IN == REG_STATUS_OFS);
  assign cmd       = PWDATA_IN[3:0];
  assign busy      = (seq_reg == SEQ_ERASE);

  // Zero-wait slave; unmapped addresses answer with an error.
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Command qualification.

  // Erase is refused while PROTECT_IN reports any block permanently protected.
  assign erase_avail = ~erase_dis & ~PROTECT_IN
                     & (state_reg != LC_BOOT_LOCKED) & (state_reg != LC_DEBUG_LOCKED);

  always_comb
  begin
    ok_adv    = 1'b0;
    ok_erase  = 1'b0;
    ok_inj_s  = 1'b0;
    ok_inj_ns = 1'b0;
    ok_reg_ns = 1'b0;
    ok_reg_s  = 1'b0;
    case (cmd)
      CMD_ADVANCE:     ok_adv    = (state_reg != LC_BOOT_LOCKED);
      CMD_ERASE_ALL:   ok_erase  = erase_avail;
      CMD_DIS_ERASE:   ok_adv    = 1'b0;
      CMD_INJ_SECURE:  ok_inj_s  = (state_reg == LC_SECURE_DEV);
      CMD_INJ_NONSEC:  ok_inj_ns = (state_reg == LC_NONSECURE_DEV);
      // Regression needs the matching key and a passing challenge.
      CMD_REGRESS_NS:  ok_reg_ns = (state_reg == LC_DEPLOYED) & nonsecure_regress_key & AUTH_OK_IN;
      CMD_REGRESS_SEC: ok_reg_s  = AUTH_OK_IN
                                 & (((state_reg == LC_NONSECURE_DEV) & secure_regress_key)
                                 | ((state_reg == LC_DEPLOYED) & secure_regress_key & nonsecure_regress_key));
      default:         ok_adv    = 1'b0;
    endcase
  end

  // Nothing is taken while an erase runs or once boot access is locked.
  assign accept    = wr_cmd & ~busy & (state_reg != LC_BOOT_LOCKED)
                   & (ok_adv | ok_erase | ok_inj_s | ok_inj_ns | ok_reg_ns | ok_reg_s
                   | (cmd == CMD_DIS_ERASE));
  assign do_reject = wr_cmd & ~accept;

  ////////////////////////////////////////////////////////////////////////////
  // Lifecycle state and erase sequence.

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      state_reg <= LC_RESET_STATE;
    else if (CE_IN)
    begin
      if (busy & ERASE_DONE_IN)
        state_reg <= LC_SECURE_DEV;
      else if (accept & ok_adv)
      begin
        case (state_reg)
          LC_SECURE_DEV:    state_reg <= LC_NONSECURE_DEV;
          LC_NONSECURE_DEV: state_reg <= LC_DEPLOYED;
          LC_DEPLOYED:      state_reg <= LC_DEBUG_LOCKED;
          default:          state_reg <= LC_BOOT_LOCKED;
        endcase
      end
      else if (accept & ok_reg_ns)
        state_reg <= LC_NONSECURE_DEV;
      else if (accept & ok_reg_s)
        state_reg <= LC_SECURE_DEV;
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      seq_reg <= SEQ_IDLE;
    else if (CE_IN)
    begin
      case (seq_reg)
        SEQ_IDLE:  if (accept & ok_erase) seq_reg <= SEQ_ERASE;
        SEQ_ERASE: if (ERASE_DONE_IN) seq_reg <= SEQ_IDLE;
        default:   seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  // The erase request is held for the whole sequence and always covers both
  // regions, so protected code in the secure region cannot survive it.
  assign ERASE_REQ_OUT = busy;
  assign ERASE_SEC_OUT = busy;
  assign ERASE_NS_OUT  = busy;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: keys (cleared by erase), erase disable, and the reject status (cleared by write).

  lsa_flag u_key_sec
  (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (SYS_RST_IN),
    .ce_in    (CE_IN),
    .set_in   (accept & ok_inj_s),
    .clr_in   (busy & ERASE_DONE_IN),
    .flag_out (secure_regress_key)
  );

  lsa_flag u_key_ns
  (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (SYS_RST_IN),
    .ce_in    (CE_IN),
    .set_in   (accept & ok_inj_ns),
    .clr_in   (busy & ERASE_DONE_IN),
    .flag_out (nonsecure_regress_key)
  );

  // No clear input is wired: disabling erase is one-way.
  lsa_flag u_erase_dis
  (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (SYS_RST_IN),
    .ce_in    (CE_IN),
    .set_in   (accept & (cmd == CMD_DIS_ERASE)),
    .clr_in   (1'b0),
    .flag_out (erase_dis)
  );

  lsa_flag u_reject
  (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (SYS_RST_IN),
    .ce_in    (CE_IN),
    .set_in   (do_reject),
    .clr_in   (wr_status & PWDATA_IN[ST_REJECT]),
    .flag_out (reject_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Debug level and serial read gating.

  always_comb
  begin
    case (state_reg)
      LC_SECURE_DEV:    dbg_level = DEBUG_FULL_ACCESS;
      LC_NONSECURE_DEV: dbg_level = DEBUG_NONSECURE_ONLY;
      default:          dbg_level = DEBUG_REFUSED;
    endcase
  end

  assign DBG_LEVEL_OUT = dbg_level;
  assign LC_STATE_OUT  = state_reg;

  logic ser_ok;
  logic grant_reg;
  logic deny_reg;

  always_comb
  begin
    case (state_reg)
      LC_SECURE_DEV:    ser_ok = 1'b1;
      LC_NONSECURE_DEV: ser_ok = (SER_CLASS_IN != SER_CLASS_SECURE);
      LC_BOOT_LOCKED:   ser_ok = 1'b0;
      default:          ser_ok = (SER_CLASS_IN == SER_CLASS_ID);
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      grant_reg <= 1'b0;
      deny_reg  <= 1'b0;
    end
    else if (CE_IN)
    begin
      grant_reg <= SER_REQ_IN & ser_ok;
      deny_reg  <= SER_REQ_IN & ~ser_ok;
    end
  end

  assign SER_GRANT_OUT = grant_reg;
  assign SER_DENY_OUT  = deny_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase so it is stable in the access.

  always_comb
  begin
    status_word                                = 32'h0000_0000;
    status_word[ST_STATE_LSB +: 3]             = state_reg;
    status_word[ST_KEY_NS]                     = nonsecure_regress_key;
    status_word[ST_KEY_SEC]                    = secure_regress_key;
    status_word[ST_ERASE_DIS]                  = erase_dis;
    status_word[ST_PROTECT]                    = PROTECT_IN;
    status_word[ST_BUSY]                       = busy;
    status_word[ST_REJECT]                     = reject_flag;
    status_word[ST_DBG_LSB +: 2]               = dbg_level;
    status_word[ST_ERASE_AVL]                  = erase_avail;
  end

  always_comb
  begin
    case (PADDR_IN)
      REG_STATUS_OFS: rdata_next = status_word;
      REG_DEBUG_OFS:  rdata_next = {30'h0000_0000, dbg_level};
      default:        rdata_next = RDATA_RESET;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      rdata_reg <= RDATA_RESET;
    else if (CE_IN & PSEL_IN & ~PENABLE_IN)
      rdata_reg <= rdata_next;
  end

  assign PRDATA_OUT = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_erase_start;
    wr_cmd & ~busy & (cmd == CMD_ERASE_ALL) & erase_avail;
  endsequence

  sequence s_erase_finish;
    busy & CE_IN & ERASE_DONE_IN;
  endsequence

  a_protect_no_erase : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    wr_cmd & (cmd == CMD_ERASE_ALL) & PROTECT_IN |=> ~busy & reject_flag)
    else $error("erase accepted under permanent protection");

  a_erase_to_secure : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    s_erase_finish |=> (state_reg == LC_SECURE_DEV) & ~busy)
    else $error("erase did not end in secure development");

  a_erase_both_regions : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    s_erase_start |=> ERASE_REQ_OUT & ERASE_SEC_OUT & ERASE_NS_OUT)
    else $error("erase did not cover both regions");

  a_deployed_to_secure : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    wr_cmd & ~busy & (cmd == CMD_REGRESS_SEC) & (state_reg == LC_DEPLOYED) & AUTH_OK_IN
    & secure_regress_key & nonsecure_regress_key |=> state_reg == LC_SECURE_DEV)
    else $error("deployed regression with both keys failed");

  a_ns_key_limit : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    wr_cmd & (cmd == CMD_REGRESS_SEC) & (state_reg == LC_DEPLOYED) & ~secure_regress_key
    |=> state_reg == LC_DEPLOYED)
    else $error("regressed past non-secure development without secure key");

  a_nsec_needs_key : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    wr_cmd & (cmd == CMD_REGRESS_SEC) & (state_reg == LC_NONSECURE_DEV) & ~secure_regress_key
    |=> state_reg == LC_NONSECURE_DEV)
    else $error("secure development reached without secure key");

  a_no_way_back : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    wr_cmd & (cmd == CMD_REGRESS_NS) & (state_reg == LC_DEPLOYED) & ~nonsecure_regress_key
    |=> state_reg == LC_DEPLOYED)
    else $error("deployed state left without non-secure key");

  a_secure_hidden : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    CE_IN & SER_REQ_IN & (SER_CLASS_IN == SER_CLASS_SECURE) & (state_reg == LC_NONSECURE_DEV)
    |=> SER_DENY_OUT & ~SER_GRANT_OUT)
    else $error("secure read granted in non-secure development");

  a_identity_only : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    CE_IN & SER_REQ_IN & (SER_CLASS_IN != SER_CLASS_ID)
    & ((state_reg == LC_DEPLOYED) | (state_reg == LC_DEBUG_LOCKED)) |=> SER_DENY_OUT)
    else $error("restricted state returned more than identity");

  a_boot_locked : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    (state_reg == LC_BOOT_LOCKED) |-> ~SER_GRANT_OUT ##1 ~SER_GRANT_OUT & ~busy)
    else $error("access granted in boot-locked state");

  a_erase_stays_off : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    erase_dis |=> erase_dis ##1 erase_dis)
    else $error("erase disable was revoked");

  a_secure_key_inject : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    $rose(secure_regress_key) |-> $past(state_reg) == LC_SECURE_DEV)
    else $error("secure key injected outside secure development");

  a_debug_map : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    (DBG_LEVEL_OUT == DEBUG_FULL_ACCESS) == (state_reg == LC_SECURE_DEV)
    && (DBG_LEVEL_OUT == DEBUG_NONSECURE_ONLY) == (state_reg == LC_NONSECURE_DEV))
    else $error("debug level does not match lifecycle state");

  a_failed_auth : assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
    wr_cmd & ((cmd == CMD_REGRESS_NS) | (cmd == CMD_REGRESS_SEC)) & ~AUTH_OK_IN
    |=> $stable(state_reg) & reject_flag & ~busy)
    else $error("failed authentication changed state");

endmodule // lsa_lifecycle

// [sim/lsa_flash_model.sv]
// Behavioural flash array standing behind the erase interface of the block.
// Assumes erase request lines are level signals on the same clock.
`timescale 1ns/10ps
module lsa_flash_model
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       load_in,
  input  wire logic [7:0] lat_in,
  input  wire logic       erase_req_in,
  input  wire logic       erase_sec_in,
  input  wire logic       erase_ns_in,
  output logic            done_out,
  output logic            sec_full_out,
  output logic            ns_full_out
);
  logic [7:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // The latency input lets the bench make the array answer promptly or slowly.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_reg      <= 8'h00;
      done_out     <= 1'b0;
      sec_full_out <= 1'b0;
      ns_full_out  <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (load_in)
      begin
        sec_full_out <= 1'b1;
        ns_full_out  <= 1'b1;
      end
      if (erase_req_in && !done_out)
      begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == lat_in)
        begin
          done_out <= 1'b1;
          if (erase_sec_in)
            sec_full_out <= 1'b0;
          if (erase_ns_in)
            ns_full_out <= 1'b0;
        end
      end
      else
        cnt_reg <= 8'h00;
    end
  end
endmodule // lsa_flash_model

// [sim/lsa_lifecycle_test.sv]
// Self-checking bench for the lifecycle block, driven over APB and the serial port.
// Assumes the flash model answers erase requests; no random stimulus.
`timescale 1ns/10ps
module lsa_lifecycle_test;
  import lsa_pkg::*;
  logic        clk, rst, psel, pen, pwr, prot, auth, sreq, load, ce;
  logic [7:0]  paddr, lat;
  logic [31:0] pwd, prd, r;
  logic [1:0]  scls;
  logic        prdy, perr, ereq, esec, ens, done, grant, deny, sfull, nfull, e;
  logic [1:0]  dbg;
  logic [2:0]  lc;
  int          error_cnt, tests_run, cyc;

  lsa_lifecycle dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .PROTECT_IN(prot), .AUTH_OK_IN(auth),
    .ERASE_REQ_OUT(ereq), .ERASE_SEC_OUT(esec), .ERASE_NS_OUT(ens), .ERASE_DONE_IN(done),
    .SER_REQ_IN(sreq), .SER_CLASS_IN(scls), .SER_GRANT_OUT(grant), .SER_DENY_OUT(deny),
    .DBG_LEVEL_OUT(dbg), .LC_STATE_OUT(lc));
  lsa_flash_model flash (.clk_in(clk), .rst_in(rst), .load_in(load), .lat_in(lat),
    .erase_req_in(ereq), .erase_sec_in(esec), .erase_ns_in(ens), .done_out(done),
    .sec_full_out(sfull), .ns_full_out(nfull));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    $display("tests %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The ceiling is far above the few hundred cycles the sequence needs.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Each command is followed by a status read; a rejection is cleared again.
  task automatic cmd(input logic [3:0] c, input logic rej);
    apb(1'b1, REG_CMD_OFS, {28'h0, c});
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk("reject", r[ST_REJECT], rej);
    if (rej)
      apb(1'b1, REG_STATUS_OFS, 32'h0000_0100);
  endtask

  task automatic st(input logic [2:0] s, input logic [1:0] d);
    @(posedge clk);
    #1;
    chk("state", lc, s);
    chk("debug", dbg, d);
  endtask

  task automatic ser_all(input logic [2:0] s);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      sreq <= 1'b1;
      scls <= c[1:0];
      @(posedge clk);
      sreq <= 1'b0;
      #1;
      chk("grant", grant, s == 3'd0 || (s == 3'd1 && c != 2) || (s < 3'd4 && c == 0));
      chk("deny", deny, !(s == 3'd0 || (s == 3'd1 && c != 2) || (s < 3'd4 && c == 0)));
    end
  endtask

  task automatic erase(input logic [7:0] l);
    lat <= l;
    load <= 1'b1;
    cmd(CMD_ERASE_ALL, 1'b0);
    load <= 1'b0;
    chk("erase both", {ereq, esec, ens}, 3'b111);
    while (ereq === 1'b1)
      @(posedge clk);
    st(3'd0, DEBUG_FULL_ACCESS);
    chk("flash", {sfull, nfull}, 2'b00);
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk("keys", r[ST_KEY_SEC:ST_KEY_NS], 2'b00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, pen, pwr, prot, auth, sreq, load} = '0;
    {paddr, pwd, scls, error_cnt, tests_run, cyc} = '0;
    lat = 8'h02;
    ce = 1'b1;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    st(3'd0, DEBUG_FULL_ACCESS);
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk("status", r[11:0], 32'h0000_0c00);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", r, 32'h0);
    apb(1'b0, REG_DEBUG_OFS, 32'h0);
    chk("debug register", r, {30'h0, DEBUG_FULL_ACCESS});
    ser_all(3'd0);
    // With the clock enable low neither a serial request nor a command may move anything.
    @(posedge clk);
    ce <= 1'b0;
    sreq <= 1'b1;
    scls <= SER_CLASS_ID;
    @(posedge clk);
    sreq <= 1'b0;
    #1;
    chk("frozen serial", {grant, deny}, 2'b00);
    apb(1'b1, REG_CMD_OFS, {28'h0, CMD_ADVANCE});
    st(3'd0, DEBUG_FULL_ACCESS);
    @(posedge clk);
    ce <= 1'b1;
    $display("reset and access test done");

    cmd(CMD_INJ_SECURE, 1'b0);
    cmd(CMD_ADVANCE, 1'b0);
    st(3'd1, DEBUG_NONSECURE_ONLY);
    ser_all(3'd1);
    cmd(CMD_INJ_SECURE, 1'b1);
    cmd(CMD_INJ_NONSEC, 1'b0);
    cmd(CMD_ADVANCE, 1'b0);
    st(3'd2, DEBUG_REFUSED);
    ser_all(3'd2);
    cmd(CMD_REGRESS_SEC, 1'b1);
    st(3'd2, DEBUG_REFUSED);
    auth <= 1'b1;
    cmd(CMD_REGRESS_SEC, 1'b0);
    st(3'd0, DEBUG_FULL_ACCESS);
    cmd(CMD_ADVANCE, 1'b0);
    cmd(CMD_ADVANCE, 1'b0);
    cmd(CMD_REGRESS_NS, 1'b0);
    st(3'd1, DEBUG_NONSECURE_ONLY);
    cmd(CMD_REGRESS_SEC, 1'b0);
    st(3'd0, DEBUG_FULL_ACCESS);
    $display("regression test done");

    cmd(CMD_ADVANCE, 1'b0);
    cmd(CMD_ADVANCE, 1'b0);
    erase(8'h02);
    cmd(CMD_ADVANCE, 1'b0);
    cmd(CMD_ADVANCE, 1'b0);
    cmd(CMD_REGRESS_NS, 1'b1);
    st(3'd2, DEBUG_REFUSED);
    erase(8'h28);
    cmd(CMD_ADVANCE, 1'b0);
    cmd(CMD_INJ_NONSEC, 1'b0);
    cmd(CMD_ADVANCE, 1'b0);
    cmd(CMD_REGRESS_SEC, 1'b1);
    cmd(CMD_REGRESS_NS, 1'b0);
    st(3'd1, DEBUG_NONSECURE_ONLY);
    cmd(CMD_REGRESS_SEC, 1'b1);
    st(3'd1, DEBUG_NONSECURE_ONLY);
    $display("erase test done");

    prot <= 1'b1;
    cmd(CMD_ERASE_ALL, 1'b1);
    chk("no erase", ereq, 1'b0);
    prot <= 1'b0;
    cmd(CMD_DIS_ERASE, 1'b0);
    cmd(CMD_ERASE_ALL, 1'b1);
    apb(1'b0, REG_STATUS_OFS, 32'h0);
    chk("erase off", {r[ST_ERASE_AVL], r[ST_ERASE_DIS], ereq}, 3'b010);
    cmd(CMD_ADVANCE, 1'b0);
    cmd(CMD_ADVANCE, 1'b0);
    st(3'd3, DEBUG_REFUSED);
    ser_all(3'd3);
    cmd(CMD_ADVANCE, 1'b0);
    st(3'd4, DEBUG_REFUSED);
    ser_all(3'd4);
    cmd(CMD_ERASE_ALL, 1'b1);
    chk("locked erase", ereq, 1'b0);
    $display("protection and lock test done");
    close_out();
  end
endmodule // lsa_lifecycle_test
